// [rtl/video_double_buffer_control.sv]
// double-buffer controller: apb registers, window walk, buffer steering
// assumes the refresh engine gives a vertical non-display start pulse, a
// display-period level and per-pixel fetch coordinates on REF_CLK
//
// Function
// - static writes always go to upper half
// - first video frame lower, then alternate
// - outside video window fetch from upper
// - video window fetched from latest frame
// - swap once, at non-display start only
// - swap needs finished frame, none in progress
// - new frame before swap cancels that swap
// - mode field 11b selects double-buffered video
// - static writes reach video window when upper shown
// - resumed video overwrites static overlay
// - disable returns display read to upper
// - only one window double buffered
// - data port advances memory position only
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "dbuf_consts.svh"

module video_double_buffer_control (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`PADDR_W-1:0] PADDR,
  input wire logic [`PDATA_W-1:0] PWDATA,
  output logic [`PDATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic VNDP_START,
  input wire logic VDISP_ACTIVE,
  input wire logic DISP_REQ,
  input wire logic [`COORD_W-1:0] DISP_X,
  input wire logic [`COORD_W-1:0] DISP_Y,
  output logic FETCH_VALID,
  output logic FETCH_BUF,
  output logic FB_WR_EN,
  output logic FB_WR_BUF,
  output logic [`COORD_W-1:0] FB_WR_X,
  output logic [`COORD_W-1:0] FB_WR_Y,
  output logic [`PIX_W-1:0] FB_WR_DATA,
  output logic TEAR_SYNC_OUT
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic [7:0] idx_w;
  logic aligned_w;
  logic is_sfx_w;
  logic is_win_w;
  logic is_data_w;
  logic is_status_w;
  logic mapped_w;
  logic wr_stb_w;
  logic data_wr_w;

  assign idx_w = PADDR[9:2];
  assign aligned_w = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
  assign is_sfx_w = aligned_w && (idx_w == `IDX_SFX);
  assign is_win_w = aligned_w && !idx_w[0] && (idx_w >= `IDX_WIN_BASE)
                    && (idx_w <= `IDX_WIN_LAST);
  assign is_data_w = aligned_w && (idx_w == `IDX_DATA_PORT);
  assign is_status_w = aligned_w && (idx_w == `IDX_STATUS);
  assign mapped_w = is_sfx_w || is_win_w || is_data_w || is_status_w;
  assign wr_stb_w = PSEL && PENABLE && PWRITE && aligned_w;
  assign data_wr_w = wr_stb_w && is_data_w;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped_w;

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  logic [7:0] sfx_w;
  logic [7:0] win_w [`WIN_REG_COUNT];
  logic [`WIN_REG_COUNT-1:0] win_written_w;

  cfg_byte_reg #(
    .INDEX(`IDX_SFX),
    .RESET_VAL(`SFX_RESET)
  ) u_sfx (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_stb(wr_stb_w),
    .wr_index(idx_w),
    .wr_data(PWDATA[7:0]),
    .value(sfx_w),
    .written()
  );

  // window position bytes sit at every second index
  for (genvar i = 0; i < `WIN_REG_COUNT; i++) begin : g_win
    cfg_byte_reg #(
      .INDEX(`IDX_WIN_BASE + 8'(2 * i)),
      .RESET_VAL(`WIN_RESET)
    ) u_win (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .wr_stb(wr_stb_w),
      .wr_index(idx_w),
      .wr_data(PWDATA[7:0]),
      .value(win_w[i]),
      .written(win_written_w[i])
    );
  end

  logic [`COORD_W-1:0] xs_w;
  logic [`COORD_W-1:0] ys_w;
  logic [`COORD_W-1:0] xe_w;
  logic [`COORD_W-1:0] ye_w;

  assign xs_w = {win_w[1][1:0], win_w[0]};
  assign ys_w = {win_w[3][1:0], win_w[2]};
  assign xe_w = {win_w[5][1:0], win_w[4]};
  assign ye_w = {win_w[7][1:0], win_w[6]};

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  logic [1:0] mode_w;
  logic mode_video_w;
  logic dbuf_on_w;

  assign mode_w = sfx_w[`SFX_MODE_HI:`SFX_MODE_LO];
  assign mode_video_w = (mode_w == `MODE_VIDEO);
  assign dbuf_on_w = mode_video_w || (mode_w == `MODE_STATIC);

  // ----------------------------------------------------------------------
  // window walk
  // ----------------------------------------------------------------------
  logic [`COORD_W-1:0] pos_x_w;
  logic [`COORD_W-1:0] pos_y_w;
  logic pos_first_w;
  logic pos_last_w;

  window_addr_gen u_walk (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .restart(|win_written_w),
    .step(data_wr_w),
    .xs(xs_w),
    .ys(ys_w),
    .xe(xe_w),
    .ye(ye_w),
    .x(pos_x_w),
    .y(pos_y_w),
    .at_first(pos_first_w),
    .at_last(pos_last_w)
  );

  // ----------------------------------------------------------------------
  // video frame tracking and buffer pointers
  // ----------------------------------------------------------------------
  dbuf_pkg::vid_state_t state_r;
  dbuf_pkg::vid_state_t state_nxt;
  dbuf_pkg::fb_half_t wr_half_r;
  dbuf_pkg::fb_half_t wr_half_nxt;
  dbuf_pkg::fb_half_t disp_half_r;
  dbuf_pkg::fb_half_t disp_half_nxt;
  logic vid_pix_w;
  logic frame_start_w;
  logic frame_end_w;
  logic swap_w;

  assign vid_pix_w = data_wr_w && mode_video_w;
  assign frame_start_w = vid_pix_w && pos_first_w;
  assign frame_end_w = vid_pix_w && pos_last_w;
  assign swap_w = VNDP_START && (state_r == dbuf_pkg::VID_DONE) && !vid_pix_w;

  // only a finished, idle frame swaps
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dbuf_pkg::VID_IDLE: begin
        if (frame_end_w) begin
          state_nxt = dbuf_pkg::VID_DONE;
        end else if (vid_pix_w) begin
          state_nxt = dbuf_pkg::VID_WRITING;
        end
      end
      dbuf_pkg::VID_WRITING: begin
        if (frame_end_w) begin
          state_nxt = dbuf_pkg::VID_DONE;
        end
      end
      dbuf_pkg::VID_DONE: begin
        if (vid_pix_w) begin
          state_nxt = frame_end_w ? dbuf_pkg::VID_DONE : dbuf_pkg::VID_WRITING;
        end else if (swap_w) begin
          state_nxt = dbuf_pkg::VID_IDLE;
        end
      end
      default: state_nxt = dbuf_pkg::VID_IDLE;
    endcase
    if (!dbuf_on_w) begin
      state_nxt = dbuf_pkg::VID_IDLE;
    end
  end

  assign wr_half_nxt = !dbuf_on_w ? dbuf_pkg::HALF_LOWER :
                       !swap_w ? wr_half_r :
                       (wr_half_r == dbuf_pkg::HALF_UPPER) ? dbuf_pkg::HALF_LOWER :
                       dbuf_pkg::HALF_UPPER;
  assign disp_half_nxt = !dbuf_on_w ? dbuf_pkg::HALF_UPPER :
                         swap_w ? wr_half_r : disp_half_r;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_r <= dbuf_pkg::VID_IDLE;
      wr_half_r <= dbuf_pkg::HALF_LOWER;
      disp_half_r <= dbuf_pkg::HALF_UPPER;
    end else begin
      state_r <= state_nxt;
      wr_half_r <= wr_half_nxt;
      disp_half_r <= disp_half_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // the single double-buffered window
  // ----------------------------------------------------------------------
  logic [`COORD_W-1:0] vxs_r;
  logic [`COORD_W-1:0] vys_r;
  logic [`COORD_W-1:0] vxe_r;
  logic [`COORD_W-1:0] vye_r;
  logic vwin_valid_r;

  // one window latched at frame start
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      vxs_r <= '0;
      vys_r <= '0;
      vxe_r <= '0;
      vye_r <= '0;
      vwin_valid_r <= 1'b0;
    end else if (!dbuf_on_w) begin
      vwin_valid_r <= 1'b0;
    end else if (frame_start_w) begin
      vxs_r <= xs_w;
      vys_r <= ys_w;
      vxe_r <= xe_w;
      vye_r <= ye_w;
      vwin_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // frame buffer write port
  // ----------------------------------------------------------------------
  dbuf_pkg::fb_half_t pix_half_w;

  // static always goes to the upper half, even when that half is the displayed video copy
  assign pix_half_w = mode_video_w ? wr_half_r : dbuf_pkg::HALF_UPPER;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      FB_WR_EN <= 1'b0;
      FB_WR_BUF <= 1'b0;
      FB_WR_X <= '0;
      FB_WR_Y <= '0;
      FB_WR_DATA <= '0;
    end else begin
      FB_WR_EN <= data_wr_w;
      if (data_wr_w) begin
        FB_WR_BUF <= pix_half_w;
        FB_WR_X <= pos_x_w;
        FB_WR_Y <= pos_y_w;
        FB_WR_DATA <= PWDATA[`PIX_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // display fetch steering
  // ----------------------------------------------------------------------
  logic in_vid_win_w;

  assign in_vid_win_w = vwin_valid_r && (DISP_X >= vxs_r) && (DISP_X <= vxe_r)
                        && (DISP_Y >= vys_r) && (DISP_Y <= vye_r);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      FETCH_VALID <= 1'b0;
      FETCH_BUF <= 1'b0;
      TEAR_SYNC_OUT <= 1'b0;
    end else begin
      FETCH_VALID <= DISP_REQ;
      TEAR_SYNC_OUT <= !VDISP_ACTIVE;
      if (DISP_REQ) begin
        FETCH_BUF <= in_vid_win_w ? disp_half_r : dbuf_pkg::HALF_UPPER;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [`PDATA_W-1:0] status_w;
  logic [`PDATA_W-1:0] rd_mux_w;
  logic [`PDATA_W-1:0] win_rd_w;

  assign win_rd_w = {24'h000000, win_w[3'(idx_w[3:1] - 3'h4)]};
  assign status_w = {24'h000000, VDISP_ACTIVE, 3'h0,
                     state_r == dbuf_pkg::VID_WRITING,
                     state_r == dbuf_pkg::VID_DONE,
                     disp_half_r == dbuf_pkg::HALF_LOWER,
                     wr_half_r == dbuf_pkg::HALF_LOWER};
  assign rd_mux_w = is_sfx_w ? {24'h000000, sfx_w} :
                    is_win_w ? win_rd_w :
                    is_status_w ? status_w : 32'h00000000;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h00000000 : rd_mux_w;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  static_upper_a: assert property (
    data_wr_w && !mode_video_w |=> FB_WR_EN && FB_WR_BUF == 1'b0
  ) else $error("static pixel not sent to upper half");

  first_lower_a: assert property (
    !dbuf_on_w ##1 (vid_pix_w && state_r == dbuf_pkg::VID_IDLE) |=> FB_WR_BUF == 1'b1
  ) else $error("first video frame not sent to lower half");

  outside_upper_a: assert property (
    DISP_REQ && !in_vid_win_w |=> FETCH_VALID && FETCH_BUF == 1'b0
  ) else $error("fetch outside video window not from upper half");

  inside_latest_a: assert property (
    DISP_REQ && in_vid_win_w |=> FETCH_BUF == $past(disp_half_r)
  ) else $error("video window fetch not from latest frame");

  swap_vndp_a: assert property (
    dbuf_on_w && $past(dbuf_on_w) && disp_half_r != $past(disp_half_r)
    |-> $past(VNDP_START)
  ) else $error("read pointer moved outside non-display start");

  swap_done_a: assert property (
    VNDP_START && dbuf_on_w && state_r == dbuf_pkg::VID_DONE && !vid_pix_w
    |=> disp_half_r == $past(wr_half_r) && state_r == dbuf_pkg::VID_IDLE
  ) else $error("finished frame not swapped at non-display start");

  busy_noswap_a: assert property (
    state_r == dbuf_pkg::VID_WRITING && dbuf_on_w
    |=> disp_half_r == $past(disp_half_r) && wr_half_r == $past(wr_half_r)
  ) else $error("pointers swapped while a frame was being written");

  disable_upper_a: assert property (
    !dbuf_on_w ##1 (DISP_REQ && !dbuf_on_w) |=> FETCH_BUF == 1'b0
  ) else $error("display not from upper half after disable");

endmodule

// [rtl/dbuf_consts.svh]
// register indexes, byte addresses, field positions and reset values of the
// double-buffer controller; included by the design files, holds no logic
`ifndef DBUF_CONSTS_SVH
`define DBUF_CONSTS_SVH

// printed register indexes (byte address is four times the index)
`define IDX_SFX        8'h36
`define IDX_WIN_BASE   8'h38
`define IDX_WIN_LAST   8'h46
`define IDX_DATA_PORT  8'h48
`define IDX_STATUS     8'h58
`define WIN_REG_COUNT  8

// apb address layout
`define PADDR_W        12
`define PDATA_W        32

// special effects register fields
`define SFX_MODE_HI    7
`define SFX_MODE_LO    6
`define SFX_RESET      8'h00
`define MODE_VIDEO     2'h3
`define MODE_STATIC    2'h1

// window coordinates: low byte plus two high bits
`define COORD_W        10
`define WIN_RESET      8'h00

// pixel carried by one data port write
`define PIX_W          16

// status register bit positions
`define ST_VDISP_BIT   7
`define ST_WRITING_BIT 3
`define ST_PEND_BIT    2
`define ST_DISP_BIT    1
`define ST_WR_BIT      0

`endif

// [rtl/dbuf_pkg.sv]
// types shared by the double-buffer controller files
// assumes dbuf_consts.svh is used alongside for all numeric constants
package dbuf_pkg;

  // which half of the frame buffer
  typedef enum logic {
    HALF_UPPER,
    HALF_LOWER
  } fb_half_t;

  // progress of the double-buffered video frame
  typedef enum logic [1:0] {
    VID_IDLE,
    VID_WRITING,
    VID_DONE
  } vid_state_t;

endpackage

// [rtl/cfg_byte_reg.sv]
// one byte-wide software register at a fixed index
// assumes a one-cycle write strobe with the decoded index alongside
`timescale 1ns/10ps
`include "dbuf_consts.svh"

module cfg_byte_reg #(
  parameter logic [7:0] INDEX = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_stb,
  input wire logic [7:0] wr_index,
  input wire logic [7:0] wr_data,
  output logic [7:0] value,
  output logic written
);

  logic [7:0] value_r;
  logic hit;

  assign hit = wr_stb && (wr_index == INDEX);
  assign value = value_r;
  assign written = hit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= RESET_VAL;
    end else if (hit) begin
      value_r <= wr_data;
    end
  end

endmodule

// [rtl/window_addr_gen.sv]
// walks the internal memory position across a window, left to right,
// top to bottom, wrapping at the end; assumes coordinates are stable
// while steps are applied
`timescale 1ns/10ps
`include "dbuf_consts.svh"

module window_addr_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic step,
  input wire logic [`COORD_W-1:0] xs,
  input wire logic [`COORD_W-1:0] ys,
  input wire logic [`COORD_W-1:0] xe,
  input wire logic [`COORD_W-1:0] ye,
  output logic [`COORD_W-1:0] x,
  output logic [`COORD_W-1:0] y,
  output logic at_first,
  output logic at_last
);

  logic [`COORD_W-1:0] x_r;
  logic [`COORD_W-1:0] y_r;
  logic [`COORD_W-1:0] x_nxt;
  logic [`COORD_W-1:0] y_nxt;
  logic restart_r;
  logic row_end;

  // after a coordinate write the walk starts again at the window origin
  assign x = restart_r ? xs : x_r;
  assign y = restart_r ? ys : y_r;
  assign at_first = (x == xs) && (y == ys);
  assign at_last = (x == xe) && (y == ye);
  assign row_end = (x == xe);
  assign x_nxt = row_end ? xs : x + `COORD_W'(1);
  assign y_nxt = !row_end ? y : (y == ye) ? ys : y + `COORD_W'(1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      x_r <= '0;
      y_r <= '0;
      restart_r <= 1'b1;
    end else if (step) begin
      x_r <= x_nxt;
      y_r <= y_nxt;
      restart_r <= 1'b0;
    end else if (restart) begin
      restart_r <= 1'b1;
    end
  end

endmodule

// [dv/host_bus_model.sv]
// host processor model: apb master that writes windows and pixels
// assumes pready is sampled at rising edges of clk
`timescale 1ns/10ps
`include "dbuf_consts.svh"

module host_bus_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`PADDR_W-1:0] paddr,
  output logic [`PDATA_W-1:0] pwdata,
  input wire logic [`PDATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // ---------------------------------------------
  // one transfer, held until pready at an edge
  // ---------------------------------------------
  // one apb read or write per call; pslverr returned with the data
  task automatic xfer(input logic w, input logic [`PADDR_W-1:0] a,
                      input logic [`PDATA_W-1:0] d, output logic [`PDATA_W-1:0] r,
                      output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // ends once pready is high at an edge; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [dv/tb.sv]
// self-checking bench of the double-buffer controller
// assumes the host model drives apb; bench plays the refresh engine
`timescale 1ns/10ps
`include "dbuf_consts.svh"

module tb;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [`PADDR_W-1:0] paddr;
  logic [`PDATA_W-1:0] pwdata, prdata;
  logic vndp_start, vdisp_active, disp_req, fetch_valid, fetch_buf;
  logic [`COORD_W-1:0] disp_x, disp_y, fb_wr_x, fb_wr_y;
  logic fb_wr_en, fb_wr_buf, tear_sync_out;
  logic [`PIX_W-1:0] fb_wr_data;
  logic [31:0] seed;
  logic wr_lower, disp_lower;
  logic [7:0] wb [8] = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00};
  logic [39:0] expq [$];
  int err_count, compares, cycles, st, pos;

  video_double_buffer_control DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .VNDP_START(vndp_start),
    .VDISP_ACTIVE(vdisp_active), .DISP_REQ(disp_req), .DISP_X(disp_x), .DISP_Y(disp_y),
    .FETCH_VALID(fetch_valid), .FETCH_BUF(fetch_buf), .FB_WR_EN(fb_wr_en),
    .FB_WR_BUF(fb_wr_buf), .FB_WR_X(fb_wr_x), .FB_WR_Y(fb_wr_y),
    .FB_WR_DATA(fb_wr_data), .TEAR_SYNC_OUT(tear_sync_out));

  host_bus_model host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------
  // checking helpers
  // ---------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // every frame buffer write matches the queued expectation
  always @(posedge ref_clk) begin
    if (rst_n && fb_wr_en === 1'b1) begin
      if (expq.size() == 0) chk(40'h1, 40'h0);
      else chk({3'h0, fb_wr_buf, fb_wr_x, fb_wr_y, fb_wr_data}, expq.pop_front());
    end
  end

  // ---------------------------------------------
  // host and refresh tasks with the buffer model
  // ---------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask

  task automatic set_mode(input logic [1:0] m);
    wr(12'h0D8, {24'h0, m, 6'h00});
    if (m != `MODE_VIDEO && m != `MODE_STATIC) begin
      disp_lower = 1'b0;
      wr_lower = 1'b1;
      st = 0;
    end
  endtask

  task automatic set_win;
    for (int i = 0; i < 8; i++) wr(12'h0E0 + 12'(8 * i), {24'h0, wb[i]});
    pos = 0;
  endtask

  // video pixels follow the write half, static ones the upper half
  // rows sent in order, first row first
  task automatic pixel(input bit video);
    logic [15:0] d;
    logic b;
    seed = lfsr(seed);
    d = seed[15:0];
    b = video ? wr_lower : 1'b0;
    if (video) st = (pos == 3) ? 2 : 1;
    expq.push_back({3'h0, b, 10'(2 + pos % 2), 10'(1 + pos / 2), d});
    wr(12'h120, {16'h0, d});
    pos = (pos + 1) % 4;
  endtask

  task automatic vndp;
    @(posedge ref_clk);
    vndp_start <= 1'b1;
    vdisp_active <= 1'b0;
    @(posedge ref_clk);
    vndp_start <= 1'b0;
    if (st == 2) begin
      disp_lower = wr_lower;
      wr_lower = ~wr_lower;
      st = 0;
    end
    #1 chk(tear_sync_out, 1'b1);
    @(posedge ref_clk);
    vdisp_active <= 1'b1;
  endtask

  task automatic fetch(input bit in_win, input logic e);
    @(posedge ref_clk);
    disp_req <= 1'b1;
    disp_x <= in_win ? 10'h3 : 10'h4;
    disp_y <= 10'h2;
    @(posedge ref_clk);
    disp_req <= 1'b0;
    #1 chk({fetch_valid, fetch_buf}, {1'b1, e});
  endtask

  task automatic fchk;
    fetch(1'b1, disp_lower);
    fetch(1'b0, 1'b0);
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {rst_n, vndp_start, vdisp_active, disp_req, disp_x, disp_y} = '0;
    {err_count, compares, cycles, st, pos} = '0;
    seed = 32'hA7B64C8A;
    wr_lower = 1'b1;
    disp_lower = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    vdisp_active <= 1'b1;
    rd(12'h0D8, 32'h0, 1'b0);
    rd(12'h004, 32'h0, 1'b1);
    set_win;
    set_mode(`MODE_VIDEO);
    rd(12'h0D8, 32'hC0, 1'b0);
    rd(12'h100, 32'h3, 1'b0);
    rd(12'h160, 32'h81, 1'b0);
    fchk;
    repeat (4) pixel(1);
    fchk;
    vndp;
    fchk;
    repeat (2) pixel(1);
    vndp;
    fchk;
    repeat (2) pixel(1);
    vndp;
    fchk;
    vndp;
    fchk;
    repeat (5) pixel(1);
    vndp;
    fchk;
    repeat (3) pixel(1);
    vndp;
    fchk;
    set_mode(`MODE_STATIC);
    repeat (4) pixel(0);
    vndp;
    fchk;
    set_mode(`MODE_VIDEO);
    repeat (4) pixel(1);
    vndp;
    fchk;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      repeat (seed[2:0]) pixel(1);
      vndp;
      fchk;
    end
    for (int m = 0; m < 4; m += 2) begin
      set_mode(`MODE_VIDEO);
      set_win;
      repeat (4) pixel(1);
      vndp;
      fchk;
      set_mode(2'(m));
      fchk;
      pixel(0);
    end
    repeat (4) @(posedge ref_clk);
    chk(40'(expq.size()), 40'h0);
    report_and_stop();
  end
endmodule
